// >>> pkg/rpss_pkg.sv
package rpss_pkg;

  // ==========================================================================
  // Command source modes and answer codes
  localparam logic [1:0]  MODE_TABLE   = 2'h0;
  localparam logic [1:0]  MODE_POS_TBL = 2'h1;
  localparam logic [1:0]  MODE_POS_SPD = 2'h2;
  localparam logic [15:0] ANS_OK       = 16'h0000;
  localparam logic [15:0] ANS_RANGE    = 16'h0003;

  // ==========================================================================
  // Value ranges checked by the device, and the fixed ramp entry used in mode 2
  localparam logic [15:0]        TBL_MIN      = 16'h0001;
  localparam logic [15:0]        TBL_MAX      = 16'h00fe;
  localparam logic [7:0]         ACCDEC_FIXED = 8'h01;
  localparam logic signed [31:0] POS_MAX      = 32'sh000fffff;
  localparam logic [15:0]        SPD_MAX      = 16'h1770;

  // ==========================================================================
  // Value after reset of every data word
  localparam logic [15:0] WORD_RST = 16'h0000;

  // ==========================================================================
  // Controller register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_POS   = 8'h04;
  localparam logic [7:0] OFS_IDX   = 8'h08;
  localparam logic [7:0] OFS_SPD   = 8'h0c;
  localparam logic [7:0] OFS_STAT  = 8'h10;
  localparam logic [7:0] OFS_ISTAT = 8'h14;
  localparam logic [7:0] OFS_IMASK = 8'h18;
  localparam logic [7:0] OFS_START = 8'h1c;

  // ==========================================================================
  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_SEL_BIT  = 2;
  localparam int CTRL_GO_BIT   = 3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDY_BIT  = 1;
  localparam int STAT_ANS_LSB  = 16;
  localparam int IRQ_DONE_BIT  = 0;
  localparam int IRQ_ERR_BIT   = 1;
  localparam int START_FWD_BIT = 0;
  localparam int START_REV_BIT = 1;

endpackage : rpss_pkg

// >>> pkg/rpss_link_if.sv
interface rpss_link_if;
  logic        position_source_select;
  logic [15:0] out_word_five;
  logic [15:0] out_word_six;
  logic [15:0] out_word_seven;
  logic        position_demand_bit;
  logic        speed_demand_bit;
  logic        forward_start_bit;
  logic        reverse_start_bit;
  logic        position_done_bit;
  logic        speed_done_bit;
  logic [15:0] answer_word;

  modport device (
    input  position_source_select,
    input  out_word_five,
    input  out_word_six,
    input  out_word_seven,
    input  position_demand_bit,
    input  speed_demand_bit,
    input  forward_start_bit,
    input  reverse_start_bit,
    output position_done_bit,
    output speed_done_bit,
    output answer_word
  );

  modport master (
    output position_source_select,
    output out_word_five,
    output out_word_six,
    output out_word_seven,
    output position_demand_bit,
    output speed_demand_bit,
    output forward_start_bit,
    output reverse_start_bit,
    input  position_done_bit,
    input  speed_done_bit,
    input  answer_word
  );
endinterface : rpss_link_if

// >>> rtl/rpss_device.sv
// Summary of operation
// - Accept settings only when selected, two stations.
// - Source parameter picks mode 0, 1 or 2.
// - Mode 0: master writes index, then demands.
// - Demand on latches value, then raises completion.
// - Stored values are volatile, lost at reset.
// - Mode 0 bad index gives range answer.
// - Mode 0 start only after position completion.
// - Mode 1: position halves, index, both demands.
// - Mode 1 speed and ramps from indexed entry.
// - Modes 1, 2 store, raise both completions.
// - Mode 1 bad position or index errors.
// - Mode 2: position halves, speed, both demands.
// - Mode 2 ramps come from table entry 1.
// - Mode 2 bad position or speed errors.
// - Modes 1, 2 start after both completions.
// - Answer 0 when normal, 3 when out of range.
module rpss_device
  import rpss_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Configuration
  input  wire logic [1:0]  command_source_param,
  input  wire logic        two_stations,
  // Stored setting towards the motion logic
  output logic [31:0]      target_position,
  output logic [15:0]      speed_value,
  output logic             speed_from_table,
  output logic [7:0]       speed_table_index,
  output logic [7:0]       accdec_table_index,
  output logic             setting_valid,
  // Start requests towards the motion logic
  output logic             move_fwd,
  output logic             move_rev,
  // Link to the master
  rpss_link_if.device      link
);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {
    DEV_IDLE,
    DEV_STORE,
    DEV_HOLD
  } rpss_dev_state_e;

  typedef struct packed {
    rpss_dev_state_e state;
    logic [1:0]      mode;
    logic            sel_s1;
    logic            sel_s2;
    logic            pdm_s1;
    logic            pdm_s2;
    logic            sdm_s1;
    logic            sdm_s2;
    logic            fwd_s1;
    logic            fwd_s2;
    logic            rev_s1;
    logic            rev_s2;
    logic [15:0]     w5_s1;
    logic [15:0]     w5_s2;
    logic [15:0]     w6_s1;
    logic [15:0]     w6_s2;
    logic [15:0]     w7_s1;
    logic [15:0]     w7_s2;
    logic            pos_done;
    logic            spd_done;
    logic [15:0]     answer;
    logic [31:0]     position;
    logic [15:0]     speed;
    logic            from_table;
    logic [7:0]      spd_index;
    logic [7:0]      ramp_index;
    logic            valid;
    logic            move_fwd;
    logic            move_rev;
  } rpss_dev_s;

  rpss_dev_s r_reg;
  rpss_dev_s r_next;

  // ==========================================================================
  // Range checks
  function automatic logic rpss_idx_ok(input logic [15:0] w);
    return (w >= TBL_MIN) && (w <= TBL_MAX);
  endfunction : rpss_idx_ok

  logic        enabled;
  logic [31:0] pos_word;
  logic        pos_bad;
  logic        req_seen;
  logic        bad;

  assign pos_word = {r_reg.w6_s2, r_reg.w5_s2};
  assign pos_bad  = ($signed(pos_word) > POS_MAX) || ($signed(pos_word) < -POS_MAX);
  // Mode 3 has no meaning, so it leaves the block deaf to demands.
  assign enabled  = r_reg.sel_s2 && two_stations && (command_source_param != 2'h3);
  assign req_seen = r_reg.pdm_s2 && ((command_source_param == MODE_TABLE) || r_reg.sdm_s2);

  always_comb begin
    unique case (command_source_param)
      MODE_TABLE:   bad = !rpss_idx_ok(r_reg.w5_s2);
      MODE_POS_TBL: bad = pos_bad || !rpss_idx_ok(r_reg.w7_s2);
      default:      bad = pos_bad || (r_reg.w7_s2 > SPD_MAX);
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    r_next = r_reg;
    // Every link input passes two flops before any decision reads it.
    r_next.sel_s1   = link.position_source_select;
    r_next.sel_s2   = r_reg.sel_s1;
    r_next.pdm_s1   = link.position_demand_bit;
    r_next.pdm_s2   = r_reg.pdm_s1;
    r_next.sdm_s1   = link.speed_demand_bit;
    r_next.sdm_s2   = r_reg.sdm_s1;
    r_next.fwd_s1   = link.forward_start_bit;
    r_next.fwd_s2   = r_reg.fwd_s1;
    r_next.rev_s1   = link.reverse_start_bit;
    r_next.rev_s2   = r_reg.rev_s1;
    r_next.w5_s1    = link.out_word_five;
    r_next.w5_s2    = r_reg.w5_s1;
    r_next.w6_s1    = link.out_word_six;
    r_next.w6_s2    = r_reg.w6_s1;
    r_next.w7_s1    = link.out_word_seven;
    r_next.w7_s2    = r_reg.w7_s1;
    // The start bits are passed on as seen; holding them back until the
    // completions are on is the master's duty, not checked here.
    r_next.move_fwd = r_reg.fwd_s2;
    r_next.move_rev = r_reg.rev_s2;

    unique case (r_reg.state)
      DEV_IDLE: begin
        if (enabled && req_seen) begin
          r_next.mode  = command_source_param;
          r_next.state = DEV_STORE;
          if (bad) begin
            // A rejected value leaves the previous setting untouched.
            r_next.answer = ANS_RANGE;
          end else begin
            r_next.answer = ANS_OK;
            r_next.valid  = 1'b1;
            unique case (command_source_param)
              MODE_TABLE: begin
                r_next.from_table = 1'b1;
                r_next.spd_index  = r_reg.w5_s2[7:0];
                r_next.ramp_index = r_reg.w5_s2[7:0];
              end
              MODE_POS_TBL: begin
                r_next.position   = pos_word;
                r_next.from_table = 1'b1;
                r_next.spd_index  = r_reg.w7_s2[7:0];
                r_next.ramp_index = r_reg.w7_s2[7:0];
              end
              default: begin
                r_next.position   = pos_word;
                r_next.speed      = r_reg.w7_s2;
                r_next.from_table = 1'b0;
                r_next.ramp_index = ACCDEC_FIXED;
              end
            endcase
          end
        end
      end
      DEV_STORE: begin
        // Completion rises only in the cycle after the value is latched.
        r_next.pos_done = 1'b1;
        r_next.spd_done = (r_reg.mode != MODE_TABLE);
        r_next.state    = DEV_HOLD;
      end
      DEV_HOLD: begin
        if (!r_reg.pdm_s2) begin
          r_next.pos_done = 1'b0;
        end
        if (!r_reg.sdm_s2) begin
          r_next.spd_done = 1'b0;
        end
        if (!r_reg.pdm_s2 && !r_reg.sdm_s2) begin
          r_next.state = DEV_IDLE;
        end
      end
    endcase
  end

  // ==========================================================================
  // Registers; the stored setting lives only here and is cleared by reset.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      r_reg       <= '0;
      r_reg.state <= DEV_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign link.position_done_bit = r_reg.pos_done;
  assign link.speed_done_bit    = r_reg.spd_done;
  assign link.answer_word       = r_reg.answer;
  assign target_position        = r_reg.position;
  assign speed_value            = r_reg.speed;
  assign speed_from_table       = r_reg.from_table;
  assign speed_table_index      = r_reg.spd_index;
  assign accdec_table_index     = r_reg.ramp_index;
  assign setting_valid          = r_reg.valid;
  assign move_fwd               = r_reg.move_fwd;
  assign move_rev               = r_reg.move_rev;

endmodule : rpss_device

// >>> rtl/rpss_master.sv
// The Wishbone slave port and the placing of the registers were left to the implementer.
module rpss_master
  import rpss_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Interrupt
  output logic             irq,
  // Link to the device
  rpss_link_if.master      link
);

  // ==========================================================================
  // State
  typedef enum logic [1:0] {
    MST_IDLE,
    MST_LOAD,
    MST_DEMAND,
    MST_RELEASE
  } rpss_mst_state_e;

  typedef struct packed {
    rpss_mst_state_e state;
    logic            ack;
    logic [31:0]     dat;
    logic [1:0]      mode;
    logic            sel;
    logic [31:0]     pos;
    logic [15:0]     idx;
    logic [15:0]     spd;
    logic [1:0]      start;
    logic [1:0]      istat;
    logic [1:0]      imask;
    logic            irq;
    logic            ready;
    logic [15:0]     answer;
    logic            pd_s1;
    logic            pd_s2;
    logic            sd_s1;
    logic            sd_s2;
    logic [15:0]     an_s1;
    logic [15:0]     an_s2;
    logic [15:0]     w5;
    logic [15:0]     w6;
    logic [15:0]     w7;
    logic            pdm;
    logic            sdm;
    logic            fwd;
    logic            rev;
  } rpss_mst_s;

  rpss_mst_s r_reg;
  rpss_mst_s r_next;

  function automatic logic [31:0] rpss_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : rpss_merge

  logic        req;
  logic        wr;
  logic        go;
  logic        both;
  logic [1:0]  ev;
  logic [31:0] rd;
  logic [31:0] m;

  assign req  = wb_cyc_i && wb_stb_i && !r_reg.ack;
  assign wr   = req && wb_we_i;
  assign both = (r_reg.mode != MODE_TABLE);

  // ==========================================================================
  // Read mux
  always_comb begin
    rd = '0;
    unique case (wb_adr_i)
      OFS_CTRL:  rd = {28'h0000000, 1'b0, r_reg.sel, r_reg.mode};
      OFS_POS:   rd = r_reg.pos;
      OFS_IDX:   rd = {16'h0000, r_reg.idx};
      OFS_SPD:   rd = {16'h0000, r_reg.spd};
      OFS_STAT:  rd = {r_reg.answer, 14'h0000, r_reg.ready, r_reg.state != MST_IDLE};
      OFS_ISTAT: rd = {30'h00000000, r_reg.istat};
      OFS_IMASK: rd = {30'h00000000, r_reg.imask};
      OFS_START: rd = {30'h00000000, r_reg.start};
      default:   rd = '0;
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    r_next       = r_reg;
    ev           = 2'h0;
    go           = 1'b0;
    m            = rpss_merge(32'h00000000, wb_dat_i, wb_sel_i);
    r_next.pd_s1 = link.position_done_bit;
    r_next.pd_s2 = r_reg.pd_s1;
    r_next.sd_s1 = link.speed_done_bit;
    r_next.sd_s2 = r_reg.sd_s1;
    r_next.an_s1 = link.answer_word;
    r_next.an_s2 = r_reg.an_s1;
    r_next.ack   = req;
    if (req) begin
      r_next.dat = rd;
    end
    if (wr) begin
      unique case (wb_adr_i)
        OFS_CTRL: begin
          if (wb_sel_i[0]) begin
            r_next.mode = m[CTRL_MODE_LSB +: 2];
            r_next.sel  = m[CTRL_SEL_BIT];
            go          = m[CTRL_GO_BIT];
          end
        end
        OFS_POS:   r_next.pos   = rpss_merge(r_reg.pos, wb_dat_i, wb_sel_i);
        OFS_IDX:   r_next.idx   = m[15:0] | (r_reg.idx & ~{{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
        OFS_SPD:   r_next.spd   = m[15:0] | (r_reg.spd & ~{{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
        OFS_ISTAT: r_next.istat = r_reg.istat & ~m[1:0];
        OFS_IMASK: r_next.imask = m[1:0];
        OFS_START: r_next.start = m[1:0];
        default: begin
        end
      endcase
    end

    unique case (r_reg.state)
      MST_IDLE: begin
        if (go) begin
          r_next.ready = 1'b0;
          r_next.w5    = (r_next.mode == MODE_TABLE) ? r_next.idx : r_next.pos[15:0];
          r_next.w6    = r_next.pos[31:16];
          r_next.w7    = (r_next.mode == MODE_POS_TBL) ? r_next.idx : r_next.spd;
          r_next.state = MST_LOAD;
        end
      end
      MST_LOAD: begin
        // Words settle one cycle ahead of the demand bits.
        r_next.pdm   = 1'b1;
        r_next.sdm   = both;
        r_next.state = MST_DEMAND;
      end
      MST_DEMAND: begin
        if (r_reg.pd_s2 && (!both || r_reg.sd_s2)) begin
          r_next.answer = r_reg.an_s2;
          r_next.ready  = (r_reg.an_s2 == ANS_OK);
          r_next.pdm    = 1'b0;
          r_next.sdm    = 1'b0;
          r_next.state  = MST_RELEASE;
        end
      end
      MST_RELEASE: begin
        if (!r_reg.pd_s2 && !r_reg.sd_s2) begin
          ev[IRQ_DONE_BIT] = 1'b1;
          ev[IRQ_ERR_BIT]  = (r_reg.answer != ANS_OK);
          r_next.state     = MST_IDLE;
        end
      end
    endcase

    // A set arriving with a clear keeps the bit set.
    r_next.istat = r_next.istat | ev;
    r_next.irq   = |(r_next.istat & r_next.imask);
    // Starts are held back until the last setting completed without error.
    r_next.fwd   = r_next.start[START_FWD_BIT] && r_next.ready;
    r_next.rev   = r_next.start[START_REV_BIT] && r_next.ready;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      r_reg       <= '0;
      r_reg.w5    <= WORD_RST;
      r_reg.state <= MST_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_dat_o                    = r_reg.dat;
  assign wb_ack_o                    = r_reg.ack;
  assign irq                         = r_reg.irq;
  assign link.position_source_select = r_reg.sel;
  assign link.out_word_five          = r_reg.w5;
  assign link.out_word_six           = r_reg.w6;
  assign link.out_word_seven         = r_reg.w7;
  assign link.position_demand_bit    = r_reg.pdm;
  assign link.speed_demand_bit       = r_reg.sdm;
  assign link.forward_start_bit      = r_reg.fwd;
  assign link.reverse_start_bit      = r_reg.rev;

endmodule : rpss_master

// >>> test/rpss_assertions.sv
module rpss_assertions
  import rpss_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // Device configuration
  input wire logic [1:0]  command_source_param,
  input wire logic        two_stations,
  // Link signals
  input wire logic        position_source_select,
  input wire logic [15:0] out_word_five,
  input wire logic [15:0] out_word_six,
  input wire logic [15:0] out_word_seven,
  input wire logic        position_demand_bit,
  input wire logic        speed_demand_bit,
  input wire logic        forward_start_bit,
  input wire logic        reverse_start_bit,
  input wire logic        position_done_bit,
  input wire logic        speed_done_bit,
  input wire logic [15:0] answer_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ==========================================================================
  // Helper logic
  logic signed [31:0] pos_w;
  logic               bad;
  logic               enabled;
  logic               seen_done_reg;

  assign pos_w   = {out_word_six, out_word_five};
  assign enabled = position_source_select && two_stations && command_source_param != 2'h3;

  always_comb begin
    case (command_source_param)
      MODE_TABLE:   bad = out_word_five < TBL_MIN || out_word_five > TBL_MAX;
      MODE_POS_TBL: bad = pos_w > POS_MAX || pos_w < -POS_MAX
                          || out_word_seven < TBL_MIN || out_word_seven > TBL_MAX;
      default:      bad = pos_w > POS_MAX || pos_w < -POS_MAX || out_word_seven > SPD_MAX;
    endcase
  end

  // A start is only legal once some setting has completed since reset.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      seen_done_reg <= 1'b0;
    end else if (position_done_bit && (speed_done_bit || command_source_param == MODE_TABLE)) begin
      seen_done_reg <= 1'b1;
    end
  end

  // ==========================================================================
  // Properties
  property p_done_latency;
    $rose(position_demand_bit) && enabled && !position_done_bit |-> ##[3:5] position_done_bit;
  endproperty
  property p_done_cause;
    $rose(position_done_bit) |-> position_demand_bit && $past(enabled, 2);
  endproperty
  property p_both_done;
    $rose(position_done_bit) |-> speed_done_bit == (command_source_param != MODE_TABLE);
  endproperty
  property p_answer;
    $rose(position_done_bit) |-> answer_word == (bad ? ANS_RANGE : ANS_OK);
  endproperty
  property p_words_stable;
    $rose(position_demand_bit) |->
      $stable(out_word_five) && $stable(out_word_six) && $stable(out_word_seven);
  endproperty
  property p_pair_demand;
    $rose(position_demand_bit) |-> speed_demand_bit == (command_source_param != MODE_TABLE);
  endproperty
  property p_release;
    position_done_bit && position_demand_bit |-> ##[1:4] !position_demand_bit;
  endproperty
  property p_clear;
    $fell(position_demand_bit) |-> ##[1:4] !position_done_bit;
  endproperty
  property p_start_order;
    forward_start_bit || reverse_start_bit |-> seen_done_reg;
  endproperty
  property p_refused;
    $rose(position_demand_bit) && !enabled |-> ##1 !position_done_bit [*8];
  endproperty

  a_done_latency: assert property (p_done_latency) else $error("completion late");
  a_done_cause: assert property (p_done_cause) else $error("completion uncaused");
  a_both_done: assert property (p_both_done) else $error("completion pair wrong");
  a_answer: assert property (p_answer) else $error("answer code wrong");
  a_words_stable: assert property (p_words_stable) else $error("words moved");
  a_pair_demand: assert property (p_pair_demand) else $error("demand pair wrong");
  a_release: assert property (p_release) else $error("demand held");
  a_clear: assert property (p_clear) else $error("completion held");
  a_start_order: assert property (p_start_order) else $error("early start");
  a_refused: assert property (p_refused) else $error("refused request done");

  c_ok: cover property ($rose(position_done_bit) && answer_word == ANS_OK);
  c_err: cover property ($rose(position_done_bit) && answer_word == ANS_RANGE);
  c_start: cover property ($rose(forward_start_bit));
endmodule : rpss_assertions

// >>> test/rpss_tb.sv
module rpss_tb
  import rpss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // Signals
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic [1:0]  command_source_param = 2'h0;
  logic        two_stations = 1'b1;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [3:0]  wb_sel = 4'hf;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
  logic        wb_ack, irq, setting_valid, move_fwd, move_rev, speed_from_table;
  logic [31:0] target_position;
  logic [15:0] speed_value;
  logic [7:0]  speed_table_index, accdec_table_index, e_aidx;
  logic        mask_on;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #25 clk_sys = ~clk_sys;

  rpss_link_if u_rpss_link_if ();
  rpss_device u_rpss_device (.clk_sys(clk_sys), .reset_n(reset_n),
    .command_source_param(command_source_param), .two_stations(two_stations),
    .target_position(target_position), .speed_value(speed_value),
    .speed_from_table(speed_from_table), .speed_table_index(speed_table_index),
    .accdec_table_index(accdec_table_index), .setting_valid(setting_valid),
    .move_fwd(move_fwd), .move_rev(move_rev), .link(u_rpss_link_if));
  rpss_master u_rpss_master (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq(irq),
    .link(u_rpss_link_if));
  rpss_assertions u_rpss_assertions (.clk_sys(clk_sys), .reset_n(reset_n),
    .command_source_param(command_source_param), .two_stations(two_stations),
    .position_source_select(u_rpss_link_if.position_source_select),
    .out_word_five(u_rpss_link_if.out_word_five), .out_word_six(u_rpss_link_if.out_word_six),
    .out_word_seven(u_rpss_link_if.out_word_seven),
    .position_demand_bit(u_rpss_link_if.position_demand_bit),
    .speed_demand_bit(u_rpss_link_if.speed_demand_bit),
    .forward_start_bit(u_rpss_link_if.forward_start_bit),
    .reverse_start_bit(u_rpss_link_if.reverse_start_bit),
    .position_done_bit(u_rpss_link_if.position_done_bit),
    .speed_done_bit(u_rpss_link_if.speed_done_bit), .answer_word(u_rpss_link_if.answer_word));

  // ==========================================================================
  // Tasks
  task automatic results;
    if (fails == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_sys);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_wdat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack !== 1'b1 && n < 40);
    if (wb_ack !== 1'b1) begin
      fails++;
      $display("MISMATCH t=%0t no bus answer", $time);
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask : wb

  // Issues one setting and checks answer, flags, interrupt and stored values.
  task automatic run(input logic [1:0] m, input logic [31:0] pos, input logic [15:0] idx,
                     input logic [15:0] spd, input logic ok);
    int n = 0;
    command_source_param <= m;
    wb(1'b1, OFS_POS, pos);
    wb(1'b1, OFS_IDX, {16'h0000, idx});
    wb(1'b1, OFS_SPD, {16'h0000, spd});
    wb(1'b1, OFS_CTRL, {28'h0000000, 2'b11, m});
    do begin
      wb(1'b0, OFS_ISTAT, 32'h0);
      n++;
    end while (rd[IRQ_DONE_BIT] !== 1'b1 && n < 40);
    chk(rd[1:0], {!ok, 1'b1}, "event flags");
    chk(irq, mask_on, "irq level");
    wb(1'b0, OFS_STAT, 32'h0);
    chk(rd[31:16], ok ? ANS_OK : ANS_RANGE, "answer");
    chk(rd[STAT_RDY_BIT], ok, "ready");
    if (ok) begin
      e_aidx = (m == MODE_POS_SPD) ? ACCDEC_FIXED : idx[7:0];
      if (m != MODE_TABLE) chk(target_position, pos, "position");
      chk(speed_from_table, m != MODE_POS_SPD, "speed source");
      if (m == MODE_POS_SPD) chk(speed_value, spd, "speed");
      else chk(speed_table_index, idx[7:0], "speed entry");
      chk(setting_valid, 1'b1, "valid");
    end
    chk(accdec_table_index, e_aidx, "ramp entry");
    wb(1'b1, OFS_ISTAT, 32'h3);
    wb(1'b0, OFS_ISTAT, 32'h0);
    chk(rd[1:0], 2'b00, "flags cleared");
    chk(irq, 1'b0, "irq cleared");
  endtask : run

  // ==========================================================================
  // Timeout and main sequence
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      results();
    end
  end

  initial begin
    mask_on = 1'b0;
    e_aidx  = 8'h00;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    wb(1'b0, OFS_STAT, 32'h0);
    chk(rd, 32'h0, "status after reset");
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    run(MODE_TABLE, 32'h0, 16'h0001, 16'h0, 1'b1);
    mask_on = 1'b1;
    wb(1'b1, OFS_IMASK, 32'h3);
    run(MODE_TABLE, 32'h0, 16'h00fe, 16'h0, 1'b1);
    run(MODE_TABLE, 32'h0, 16'h0000, 16'h0, 1'b0);
    run(MODE_TABLE, 32'h0, 16'h00ff, 16'h0, 1'b0);
    run(MODE_POS_TBL, 32'h000fffff, 16'h0002, 16'h0, 1'b1);
    run(MODE_POS_TBL, 32'hfff00000, 16'h0002, 16'h0, 1'b0);
    run(MODE_POS_TBL, 32'hfff00001, 16'h00ff, 16'h0, 1'b0);
    run(MODE_POS_TBL, 32'hfff00001, 16'h00fe, 16'h0, 1'b1);
    run(MODE_POS_SPD, 32'h00100000, 16'h0000, 16'h0010, 1'b0);
    run(MODE_POS_SPD, 32'h00000123, 16'h0000, 16'h1771, 1'b0);
    run(MODE_POS_SPD, 32'h00000123, 16'h0000, 16'h1770, 1'b1);
    wb(1'b1, OFS_START, 32'h3);
    repeat (6) @(posedge clk_sys);
    chk(u_rpss_link_if.forward_start_bit, 1'b1, "forward start");
    chk(move_fwd, 1'b1, "forward move");
    chk(move_rev, 1'b1, "reverse move");
    wb(1'b1, OFS_START, 32'h0);
    run(MODE_POS_SPD, 32'h0, 16'h0000, 16'hffff, 1'b0);
    wb(1'b1, OFS_START, 32'h2);
    repeat (6) @(posedge clk_sys);
    chk(u_rpss_link_if.reverse_start_bit, 1'b0, "reverse start held");
    chk(move_rev, 1'b0, "reverse move held");
    wb(1'b1, OFS_START, 32'h0);
    // The refused request leaves the master waiting, so a reset ends it.
    two_stations         <= 1'b0;
    command_source_param <= MODE_TABLE;
    wb(1'b1, OFS_CTRL, 32'h0000000c);
    repeat (20) @(posedge clk_sys);
    chk(u_rpss_link_if.position_done_bit, 1'b0, "single station refused");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk(setting_valid, 1'b0, "setting lost");
    chk(target_position, 32'h0, "position lost");
    chk(accdec_table_index, 8'h00, "ramp lost");
    reset_n      <= 1'b1;
    two_stations <= 1'b1;
    results();
  end
endmodule : rpss_tb
